/* design/eqcrb_pkg.sv */
// Package with offsets, field layouts, reset values and carriers.
package eqcrb_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int unsigned EQCRB_NREG = 15;
  localparam int unsigned EQCRB_CH0B_TAPS = 7;
  localparam int unsigned EQCRB_CH1A_TAPS = 5;
  localparam int unsigned EQCRB_IDX_CH0B_TAP = 0;
  localparam int unsigned EQCRB_IDX_CH0B_DRV = 7;
  localparam int unsigned EQCRB_IDX_CH0B_OFS = 8;
  localparam int unsigned EQCRB_IDX_CH0B_AMP = 9;
  localparam int unsigned EQCRB_IDX_CH1A_TAP = 10;

  localparam logic [7:0] EQCRB_CH0B_TAP2_COEFF_OFS = 8'h22;
  localparam logic [7:0] EQCRB_CH0B_TAP3_COEFF_OFS = 8'h23;
  localparam logic [7:0] EQCRB_CH0B_TAP4_COEFF_OFS = 8'h24;
  localparam logic [7:0] EQCRB_CH0B_TAP5_COEFF_OFS = 8'h25;
  localparam logic [7:0] EQCRB_CH0B_TAP6_COEFF_OFS = 8'h26;
  localparam logic [7:0] EQCRB_CH0B_TAP7_COEFF_OFS = 8'h27;
  localparam logic [7:0] EQCRB_CH0B_TAP8_COEFF_OFS = 8'h28;
  localparam logic [7:0] EQCRB_CH0B_DRIVER_GAIN_OFS = 8'h29;
  localparam logic [7:0] EQCRB_CH0B_OFFSET_CTRL_OFS = 8'h2a;
  localparam logic [7:0] EQCRB_CH0B_AMPLITUDE_TARGET_OFS = 8'h2b;
  localparam logic [7:0] EQCRB_CH1A_TAP0_COEFF_OFS = 8'h40;

  // Index order of the storage array, highest index first.
  localparam logic [EQCRB_NREG-1:0][7:0] EQCRB_OFFS = {
    8'h44, 8'h43, 8'h42, 8'h41, EQCRB_CH1A_TAP0_COEFF_OFS,
    EQCRB_CH0B_AMPLITUDE_TARGET_OFS, EQCRB_CH0B_OFFSET_CTRL_OFS,
    EQCRB_CH0B_DRIVER_GAIN_OFS, EQCRB_CH0B_TAP8_COEFF_OFS,
    EQCRB_CH0B_TAP7_COEFF_OFS, EQCRB_CH0B_TAP6_COEFF_OFS,
    EQCRB_CH0B_TAP5_COEFF_OFS, EQCRB_CH0B_TAP4_COEFF_OFS,
    EQCRB_CH0B_TAP3_COEFF_OFS, EQCRB_CH0B_TAP2_COEFF_OFS};

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned EQCRB_TAP_EN_BIT = 7;
  localparam int unsigned EQCRB_TAP_SIGN_BIT = 6;
  localparam int unsigned EQCRB_TAP_MAG_MSB = 5;
  localparam int unsigned EQCRB_DRV_GAIN_MSB = 5;
  localparam int unsigned EQCRB_OFS_AUTO_BIT = 6;
  localparam int unsigned EQCRB_OFS_SIGN_BIT = 5;
  localparam int unsigned EQCRB_OFS_MAG_MSB = 4;
  localparam int unsigned EQCRB_AMP_MSB = 2;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] EQCRB_RST_CH0B_TAP2 = 8'hff;
  localparam logic [7:0] EQCRB_RST_CH0B_TAP3 = 8'ha8;
  localparam logic [7:0] EQCRB_RST_CH0B_TAP4 = 8'h84;
  localparam logic [7:0] EQCRB_RST_TAP_ZERO = 8'hc0;
  localparam logic [7:0] EQCRB_RST_CH0B_DRV = 8'h3f;
  localparam logic [7:0] EQCRB_RST_CH0B_OFS = 8'h40;
  localparam logic [7:0] EQCRB_RST_CH0B_AMP = 8'h04;
  localparam logic [7:0] EQCRB_RST_CH1A_TAP4 = 8'hdf;

  localparam logic [EQCRB_NREG-1:0][7:0] EQCRB_RSTV = {
    EQCRB_RST_CH1A_TAP4, EQCRB_RST_TAP_ZERO, EQCRB_RST_TAP_ZERO,
    EQCRB_RST_TAP_ZERO, EQCRB_RST_TAP_ZERO,
    EQCRB_RST_CH0B_AMP, EQCRB_RST_CH0B_OFS, EQCRB_RST_CH0B_DRV,
    EQCRB_RST_TAP_ZERO, EQCRB_RST_TAP_ZERO, EQCRB_RST_TAP_ZERO,
    EQCRB_RST_TAP_ZERO, EQCRB_RST_CH0B_TAP4, EQCRB_RST_CH0B_TAP3,
    EQCRB_RST_CH0B_TAP2};

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eqcrb_req_s;

  typedef struct packed {
    logic       en;
    logic       positive;
    logic [5:0] mag;
  } eqcrb_tap_s;

  typedef struct packed {
    logic       auto_en;
    logic       manual_sign;
    logic [4:0] manual_mag;
  } eqcrb_ofs_s;

endpackage

/* design/eqcrb_reg8.sv */
// One byte-wide configuration register with a fixed reset value.
module eqcrb_reg8 #(
  parameter logic [7:0] RST = 8'h00
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Write side
  input  wire logic       we,
  input  wire logic [7:0] d,
  // Stored value
  output logic      [7:0] q
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= RST;
    end else if (we) begin
      q <= d;
    end
  end

endmodule

/* design/eqcrb_bank.sv */
// Equalizer coefficient register bank with byte register port.
module eqcrb_bank
  import eqcrb_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic                          ce,
  // Register port from the serial protocol engine
  input  wire eqcrb_pkg::eqcrb_req_s         req_i,
  output logic      [7:0]                    rdata_o,
  output logic                               ack_o,
  output logic                               err_o,
  // Channel 0, second coefficient set fields
  output eqcrb_pkg::eqcrb_tap_s [6:0]        ch0b_tap_o,
  output logic      [5:0]                    ch0b_drv_gain_o,
  output eqcrb_pkg::eqcrb_ofs_s              ch0b_ofs_o,
  output logic      [2:0]                    ch0b_gain_control_level_target_o,
  // Channel 1, first coefficient set fields
  output eqcrb_pkg::eqcrb_tap_s [4:0]        ch1a_tap_o
);

  import eqcrb_pkg::*;

  // ==========================================================================
  // Decode
  // ==========================================================================
  logic [EQCRB_NREG-1:0][7:0] q;
  logic [EQCRB_NREG-1:0]      hit;
  logic [EQCRB_NREG-1:0]      reg_we;
  logic [EQCRB_NREG:0][7:0]   rd_chain;
  wire                        any_hit = |hit;
  wire                        access = req_i.wr | req_i.rd;
  wire  [7:0]                 rd_word = rd_chain[EQCRB_NREG];

  assign rd_chain[0] = 8'h00;

  // Each register is its own flop set, so no set aliases another.
  genvar gi;
  generate
    for (gi = 0; gi < EQCRB_NREG; gi++) begin : g_reg
      assign hit[gi] = req_i.addr == EQCRB_OFFS[gi];
      assign reg_we[gi] = ce & req_i.wr & hit[gi];
      assign rd_chain[gi+1] = rd_chain[gi] | (hit[gi] ? q[gi] : 8'h00);
      eqcrb_reg8 #(
        .RST (EQCRB_RSTV[gi])
      ) u_reg (
        .clk   (clk),
        .rst_b (rst_b),
        .we    (reg_we[gi]),
        .d     (req_i.wdata),
        .q     (q[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Read answer
  // ==========================================================================
  logic [7:0] rdata_r;
  logic       ack_r;
  logic       err_r;

  // An unmapped read answers zero and flags the miss; writes there vanish.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
      ack_r   <= 1'b0;
      err_r   <= 1'b0;
    end else if (ce) begin
      ack_r <= access;
      err_r <= access & ~any_hit;
      if (req_i.rd) begin
        rdata_r <= rd_word;
      end
    end
  end

  assign rdata_o = rdata_r;
  assign ack_o   = ack_r;
  assign err_o   = err_r;

  // ==========================================================================
  // Field outputs
  // ==========================================================================
  generate
    for (gi = 0; gi < EQCRB_CH0B_TAPS; gi++) begin : g_ch0b
      assign ch0b_tap_o[gi].en =
        q[EQCRB_IDX_CH0B_TAP+gi][EQCRB_TAP_EN_BIT];
      assign ch0b_tap_o[gi].positive =
        q[EQCRB_IDX_CH0B_TAP+gi][EQCRB_TAP_SIGN_BIT] == 1'b1;
      assign ch0b_tap_o[gi].mag =
        q[EQCRB_IDX_CH0B_TAP+gi][EQCRB_TAP_MAG_MSB:0];
    end
    for (gi = 0; gi < EQCRB_CH1A_TAPS; gi++) begin : g_ch1a
      assign ch1a_tap_o[gi].en =
        q[EQCRB_IDX_CH1A_TAP+gi][EQCRB_TAP_EN_BIT];
      assign ch1a_tap_o[gi].positive =
        q[EQCRB_IDX_CH1A_TAP+gi][EQCRB_TAP_SIGN_BIT] == 1'b1;
      assign ch1a_tap_o[gi].mag =
        q[EQCRB_IDX_CH1A_TAP+gi][EQCRB_TAP_MAG_MSB:0];
    end
  endgenerate

  // The unused top bits stay stored and readable but drive nothing.
  assign ch0b_drv_gain_o =
    q[EQCRB_IDX_CH0B_DRV][EQCRB_DRV_GAIN_MSB:0];
  assign ch0b_ofs_o.auto_en =
    q[EQCRB_IDX_CH0B_OFS][EQCRB_OFS_AUTO_BIT];
  assign ch0b_ofs_o.manual_sign =
    q[EQCRB_IDX_CH0B_OFS][EQCRB_OFS_SIGN_BIT];
  assign ch0b_ofs_o.manual_mag =
    q[EQCRB_IDX_CH0B_OFS][EQCRB_OFS_MAG_MSB:0];
  assign ch0b_gain_control_level_target_o =
    q[EQCRB_IDX_CH0B_AMP][EQCRB_AMP_MSB:0];

  // ==========================================================================
  // Assertions
  // ==========================================================================
  logic       first_r;
  logic [7:0] wd_last_r;

  // Marks the first edge after reset release so reset values can be checked.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_last_r <= 8'h00;
    end else begin
      wd_last_r <= req_i.wdata;
    end
  end

  property p_tap_layout;
    @(posedge clk) disable iff (!rst_b)
    ch0b_tap_o[3] == q[3] && ch1a_tap_o[2] == q[12];
  endproperty
  a_tap_layout: assert property (p_tap_layout)
    else $error("Tap field layout does not match stored byte.");

  property p_sign_decode;
    @(posedge clk) disable iff (!rst_b)
    ch0b_tap_o[1].positive == q[1][6] && ch1a_tap_o[0].positive == q[10][6];
  endproperty
  a_sign_decode: assert property (p_sign_decode)
    else $error("Tap sign decode is inverted.");

  property p_rst_ch0b_tap2;
    @(posedge clk) disable iff (!rst_b)
    first_r |-> ch0b_tap_o[0] ==
      eqcrb_tap_s'{en: 1'b1, positive: 1'b1, mag: 6'h3f};
  endproperty
  a_rst_ch0b_tap2: assert property (p_rst_ch0b_tap2)
    else $error("Channel 0 tap 2 reset value wrong.");

  property p_rst_ch0b_tap34;
    @(posedge clk) disable iff (!rst_b)
    first_r |-> q[1] == 8'ha8 && q[2] == 8'h84;
  endproperty
  a_rst_ch0b_tap34: assert property (p_rst_ch0b_tap34)
    else $error("Channel 0 tap 3 or tap 4 reset value wrong.");

  property p_rst_zero_taps;
    @(posedge clk) disable iff (!rst_b)
    first_r |-> q[6:3] == {4{8'hc0}} && q[13:10] == {4{8'hc0}};
  endproperty
  a_rst_zero_taps: assert property (p_rst_zero_taps)
    else $error("Zero-gain tap reset value wrong.");

  property p_rst_misc;
    @(posedge clk) disable iff (!rst_b)
    first_r |-> q[7] == 8'h3f && q[8] == 8'h40 && q[9] == 8'h04
      && ch1a_tap_o[4].mag == 6'h1f;
  endproperty
  a_rst_misc: assert property (p_rst_misc)
    else $error("Driver, offset, amplitude or ch1 tap 4 reset wrong.");

  property p_field_map;
    @(posedge clk) disable iff (!rst_b)
    ch0b_drv_gain_o == q[7][5:0] && ch0b_ofs_o == q[8][6:0]
      && ch0b_gain_control_level_target_o == q[9][2:0];
  endproperty
  a_field_map: assert property (p_field_map)
    else $error("Control field outputs do not follow their registers.");

  property p_ch1_write;
    @(posedge clk) disable iff (!rst_b)
    ce && req_i.wr && req_i.addr == 8'h43
      |=> ch1a_tap_o[3] == wd_last_r && $stable(q[12]);
  endproperty
  a_ch1_write: assert property (p_ch1_write)
    else $error("Write to 0x43 did not land in channel 1 tap 3 only.");

  property p_readback;
    @(posedge clk) disable iff (!rst_b)
    ce && req_i.wr && req_i.addr == 8'h2a ##1
      ce && req_i.rd && !req_i.wr && req_i.addr == 8'h2a
      |=> ack_o && !err_o && rdata_o == $past(wd_last_r);
  endproperty
  a_readback: assert property (p_readback)
    else $error("Read did not return the last written value.");

  property p_unmapped;
    @(posedge clk) disable iff (!rst_b)
    ce && req_i.wr && req_i.addr == 8'h30 |=> err_o && $stable(q);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("Unmapped write changed storage or was not flagged.");

  property p_freeze;
    @(posedge clk) disable iff (!rst_b)
    !ce |=> $stable(q) && $stable(rdata_o) && $stable(ack_o);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("State moved while clock enable was low.");

  property p_ack_follows;
    @(posedge clk) disable iff (!rst_b)
    ce && (req_i.wr || req_i.rd) |=> ack_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("Accepted access was not acknowledged.");

  property p_idle;
    @(posedge clk) disable iff (!rst_b)
    ce && !req_i.wr && !req_i.rd |=> !ack_o && !err_o;
  endproperty
  a_idle: assert property (p_idle)
    else $error("Acknowledge or error without an access.");

  property p_err_unmapped_rd;
    @(posedge clk) disable iff (!rst_b)
    ce && req_i.rd && !any_hit |=> err_o && rdata_o == 8'h00;
  endproperty
  a_err_unmapped_rd: assert property (p_err_unmapped_rd)
    else $error("Unmapped read did not answer zero with error.");

  property p_mapped_no_err;
    @(posedge clk) disable iff (!rst_b)
    ce && (req_i.wr || req_i.rd) && any_hit |=> !err_o;
  endproperty
  a_mapped_no_err: assert property (p_mapped_no_err)
    else $error("Mapped access flagged as an error.");

  property p_rd_wr_same;
    @(posedge clk) disable iff (!rst_b)
    ce && req_i.rd && req_i.wr && req_i.addr == 8'h44
      |=> rdata_o == $past(q[14]) && q[14] == wd_last_r;
  endproperty
  a_rd_wr_same: assert property (p_rd_wr_same)
    else $error("Read with write did not return the old value.");

  property p_ch0b_write;
    @(posedge clk) disable iff (!rst_b)
    ce && req_i.wr && req_i.addr == 8'h22 |=> ch0b_tap_o[0] == wd_last_r;
  endproperty
  a_ch0b_write: assert property (p_ch0b_write)
    else $error("Write to 0x22 did not land in channel 0 tap 2.");

  property p_base_addr;
    @(posedge clk) disable iff (!rst_b)
    ce && req_i.wr && req_i.addr == 8'h40
      |=> ch1a_tap_o[0] == wd_last_r && $stable(q[9:0]);
  endproperty
  a_base_addr: assert property (p_base_addr)
    else $error("Write to 0x40 did not land in channel 1 tap 0 only.");

  property p_drv_write;
    @(posedge clk) disable iff (!rst_b)
    ce && req_i.wr && req_i.addr == 8'h29 |=> q[7] == wd_last_r;
  endproperty
  a_drv_write: assert property (p_drv_write)
    else $error("Driver register did not store all eight bits.");

  property p_ofs_write;
    @(posedge clk) disable iff (!rst_b)
    ce && req_i.wr && req_i.addr == 8'h2a
      |=> ch0b_ofs_o == wd_last_r[6:0];
  endproperty
  a_ofs_write: assert property (p_ofs_write)
    else $error("Offset fields do not follow the written byte.");

  property p_amp_write;
    @(posedge clk) disable iff (!rst_b)
    ce && req_i.wr && req_i.addr == 8'h2b
      |=> ch0b_gain_control_level_target_o == wd_last_r[2:0];
  endproperty
  a_amp_write: assert property (p_amp_write)
    else $error("Amplitude target does not follow the written byte.");

  property p_rd_hold;
    @(posedge clk) disable iff (!rst_b)
    !(ce && req_i.rd) |=> $stable(rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("Read data moved without an accepted read.");

endmodule

/* tb/tb_eqcrb_bank.sv */
// Self-checking testbench for the equalizer coefficient register bank.
module tb_eqcrb_bank;
  timeunit 1ns;
  timeprecision 1ps;
  import eqcrb_pkg::*;

  // ==========================================================================
  // Signals and design instance
  // ==========================================================================
  logic                   clk;
  logic                   rst_b;
  logic                   ce;
  eqcrb_req_s             req;
  logic       [7:0]       rdata_o;
  logic                   ack_o;
  logic                   err_o;
  eqcrb_tap_s [6:0]       ch0b_tap_o;
  logic       [5:0]       ch0b_drv_gain_o;
  eqcrb_ofs_s             ch0b_ofs_o;
  logic       [2:0]       ch0b_amp_o;
  eqcrb_tap_s [4:0]       ch1a_tap_o;
  int                     err_count;
  int                     num_checks;
  logic       [7:0]       mdl [15];
  logic       [7:0]       pat;

  // Offsets and reset values in storage order, written out independently.
  localparam logic [7:0] ADR [15] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26,
    8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44};
  localparam logic [7:0] RSTV [15] = '{8'hff, 8'ha8, 8'h84, 8'hc0, 8'hc0,
    8'hc0, 8'hc0, 8'h3f, 8'h40, 8'h04, 8'hc0, 8'hc0, 8'hc0, 8'hc0, 8'hdf};
  localparam logic [7:0] BAD [6] = '{8'h21, 8'h2c, 8'h30, 8'h3f, 8'h45,
    8'hff};

  eqcrb_bank uut (
    .clk                              (clk),
    .rst_b                            (rst_b),
    .ce                               (ce),
    .req_i                            (req),
    .rdata_o                          (rdata_o),
    .ack_o                            (ack_o),
    .err_o                            (err_o),
    .ch0b_tap_o                       (ch0b_tap_o),
    .ch0b_drv_gain_o                  (ch0b_drv_gain_o),
    .ch0b_ofs_o                       (ch0b_ofs_o),
    .ch0b_gain_control_level_target_o (ch0b_amp_o),
    .ch1a_tap_o                       (ch1a_tap_o)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================================
  // Field view and comparisons
  // ==========================================================================
  // Only the used bits reach the field outputs, so unused bits read as zero.
  function automatic logic [7:0] obs(input int i);
    if (i < 7) return ch0b_tap_o[i];
    if (i == 7) return {2'b00, ch0b_drv_gain_o};
    if (i == 8) return {1'b0, ch0b_ofs_o};
    if (i == 9) return {5'b00000, ch0b_amp_o};
    return ch1a_tap_o[i-10];
  endfunction

  function automatic logic [7:0] msk(input int i);
    if (i == 7) return 8'h3f;
    if (i == 8) return 8'h7f;
    if (i == 9) return 8'h07;
    return 8'hff;
  endfunction

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  // ==========================================================================
  // Register port access
  // ==========================================================================
  // Request held over one taking edge; the answer is looked at right after it.
  task automatic acc(input logic w, input logic r, input logic [7:0] a,
                     input logic [7:0] d, input logic e,
                     input logic [7:0] rexp);
    @(posedge clk);
    #1;
    req.wr = w;
    req.rd = r;
    req.addr = a;
    req.wdata = d;
    @(posedge clk);
    #1;
    req.wr = 1'b0;
    req.rd = 1'b0;
    cmp1(ack_o, 1'b1);
    cmp1(err_o, e);
    if (r) cmp8(rdata_o, rexp);
  endtask

  task automatic check_all();
    for (int i = 0; i < 15; i++) begin
      cmp8(obs(i), mdl[i] & msk(i));
      acc(1'b0, 1'b1, ADR[i], 8'h00, 1'b0, mdl[i]);
    end
  endtask

  task automatic results();
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #100us;
    err_count++;
    results();
  end

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    err_count = 0;
    num_checks = 0;
    rst_b = 1'b0;
    ce = 1'b1;
    req = '0;
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    mdl = RSTV;
    check_all();
    // Two complementary passes toggle every stored bit, unused ones too.
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 15; i++) begin
        pat = 8'h5a ^ (8'h13 * 8'(i));
        if (p == 1) pat = ~pat;
        acc(1'b1, 1'b0, ADR[i], pat, 1'b0, 8'h00);
        mdl[i] = pat;
      end
      check_all();
    end
    acc(1'b1, 1'b0, 8'h23, 8'h40, 1'b0, 8'h00);
    cmp1(ch0b_tap_o[1].positive, 1'b1);
    cmp1(ch0b_tap_o[1].en, 1'b0);
    acc(1'b1, 1'b0, 8'h23, 8'h80, 1'b0, 8'h00);
    cmp1(ch0b_tap_o[1].positive, 1'b0);
    cmp1(ch0b_tap_o[1].en, 1'b1);
    mdl[1] = 8'h80;
    // A write followed at once by a read of the same byte returns it.
    @(posedge clk);
    #1;
    req.wr = 1'b1;
    req.addr = 8'h2a;
    req.wdata = 8'h95;
    @(posedge clk);
    #1;
    req.wr = 1'b0;
    req.rd = 1'b1;
    cmp1(ack_o, 1'b1);
    @(posedge clk);
    #1;
    req.rd = 1'b0;
    cmp1(ack_o, 1'b1);
    cmp8(rdata_o, 8'h95);
    mdl[8] = 8'h95;
    foreach (BAD[k]) begin
      acc(1'b1, 1'b0, BAD[k], 8'h00, 1'b1, 8'h00);
      acc(1'b0, 1'b1, BAD[k], 8'h00, 1'b1, 8'h00);
    end
    check_all();
    // A read and a write together return the old value; the write lands.
    acc(1'b1, 1'b1, 8'h44, 8'h77, 1'b0, mdl[14]);
    mdl[14] = 8'h77;
    cmp8(obs(14), 8'h77);
    // With the clock enable low nothing is taken.
    @(posedge clk);
    #1;
    ce = 1'b0;
    req.wr = 1'b1;
    req.addr = 8'h22;
    req.wdata = ~mdl[0];
    repeat (3) @(posedge clk);
    #1;
    cmp1(ack_o, 1'b0);
    cmp8(obs(0), mdl[0]);
    req = '0;
    ce = 1'b1;
    // A second reset in mid-run brings every register back.
    rst_b = 1'b0;
    @(posedge clk);
    #1;
    rst_b = 1'b1;
    mdl = RSTV;
    check_all();
    results();
  end

endmodule
